// [clock_source_defines.svh]
`ifndef CLOCK_SOURCE_DEFINES_SVH
`define CLOCK_SOURCE_DEFINES_SVH

// System clock rate used to turn times into cycle counts.
`define MCLK_MHZ            20

// Tree-offset select codes.
`define SKEW_NATURAL        2'h0
`define SKEW_MEDIUM         2'h1
`define SKEW_MAXIMUM        2'h2
`define SKEW_RESERVED       2'h3

// Tree offset step times in nanoseconds.
`define D1_NS               100
`define D2_NS               100
`define D3_NS               150
`define D4_NS               150

// Least times round up to whole cycles.
`define D1_CYC              ((`D1_NS * `MCLK_MHZ + 999) / 1000)
`define D2_CYC              ((`D2_NS * `MCLK_MHZ + 999) / 1000)
`define D3_CYC              ((`D3_NS * `MCLK_MHZ + 999) / 1000)
`define D4_CYC              ((`D4_NS * `MCLK_MHZ + 999) / 1000)
`define TREE_DEPTH          (`D1_CYC + `D2_CYC + `D3_CYC + `D4_CYC)
`define TAP_W               4

// Frequency multiplier of the loop, fixed in hardware.
`define PLL_MULT            4
`define PLL_MULT_LOG2       2
`define PERIOD_W            12
`define PERIOD_MAX          12'hFFF
`define PERIOD_MIN          12'h004
`define PERIOD_TOL          12'h001
`define LOCK_PERIODS        3'h4
`define LOCK_CNT_W          3

`define EVENT_CNT_W         8

`endif

// [clock_source_pkg.sv]
package clock_source_pkg;

  typedef enum logic [1:0] {
    PLL_OFF,
    PLL_MEASURE,
    PLL_ACQUIRE,
    PLL_LOCKED
  } pll_state_type;

  typedef struct packed {
    logic tree_copy_a;
    logic tree_copy_b;
    logic tree_copy_c;
  } tree_type;

  typedef struct packed {
    logic pll_powered;
    logic pll_locked;
    logic direct_mode;
    logic skew_reserved;
  } clk_status_type;

endpackage

// [tree_delay_line.sv]
`timescale 1ns/1ps
`include "clock_source_defines.svh"

// Delays a one-cycle tick by a selectable number of cycles, plus one register stage.
module tree_delay_line
#(
  parameter int DEPTH = 10
)
(
  input  wire logic              mclk_in,
  input  wire logic              rst_in,
  input  wire logic              tick_in,
  input  wire logic [`TAP_W-1:0] tap_in,
  output logic                   tick_out
);

  logic [DEPTH-1:0] shift_ff;
  logic             tick_ff;

  always_ff @(posedge mclk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      shift_ff <= '0;
    end
    else
    begin
      shift_ff <= {shift_ff[DEPTH-2:0], tick_in};
    end
  end

  // The tap is read one stage early into an output flop, so the delay is unchanged.
  always_ff @(posedge mclk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      tick_ff <= 1'b0;
    end
    else if (tap_in == '0)
    begin
      tick_ff <= tick_in;
    end
    else
    begin
      tick_ff <= shift_ff[tap_in - `TAP_W'(1)];
    end
  end

  always_comb
  begin
    tick_out = tick_ff;
  end

endmodule

// [tmr_register.sv]
`timescale 1ns/1ps
`include "clock_source_defines.svh"

// Three copies of one state word, each loaded on the tick of its own tree, read through a vote.
module tmr_register
#(
  parameter int WIDTH = 1
)
(
  input  wire logic                            mclk_in,
  input  wire logic                            rst_in,
  input  wire clock_source_pkg::tree_type      tree_in,
  input  wire logic            [WIDTH-1:0]     d_in,
  output logic                 [WIDTH-1:0]     q_out
);
  import clock_source_pkg::*;

  logic [WIDTH-1:0] copy_a_ff;
  logic [WIDTH-1:0] copy_b_ff;
  logic [WIDTH-1:0] copy_c_ff;

  always_ff @(posedge mclk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      copy_a_ff <= '0;
    end
    else if (tree_in.tree_copy_a)
    begin
      copy_a_ff <= d_in;
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      copy_b_ff <= '0;
    end
    else if (tree_in.tree_copy_b)
    begin
      copy_b_ff <= d_in;
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      copy_c_ff <= '0;
    end
    else if (tree_in.tree_copy_c)
    begin
      copy_c_ff <= d_in;
    end
  end

  always_comb
  begin
    q_out = (copy_a_ff & copy_b_ff) | (copy_b_ff & copy_c_ff) | (copy_a_ff & copy_c_ff);
  end

endmodule

// [clock_source_skew.sv]
`timescale 1ns/1ps
`include "clock_source_defines.svh"

// What this block does
// - Two independent clock domains exist, one for the core and one for the bus interface.
// - The bus-interface trees are fed only from the external bus clock input.
// - Bus-side activity is carried across into the core domain.
// - Core logic runs on the core trees and the bus interface never uses them.
// - With the direct select high the reference clock is the core clock unchanged.
// - With the direct select low the core clock comes from the loop at four times the reference.
// - The loop is powered down whenever the direct select is high.
// - The multiplier is fixed and the loop is steered only by dedicated pins.
// - The settled output rises once the loop is locked and delivering its clock.
// - State is held in three copies, each on its own tree, for both core and bus clocks.
// - Code 00 gives the natural skew between the three trees.
// - Code 01 offsets the second tree by D1 and the third by a further D3.
// - Code 10 offsets the second tree by D1 + D2 and the third by a further D3 + D4.
module clock_source_skew
(
  input  wire logic                                mclk_in,
  input  wire logic                                rst_in,
  input  wire logic                                ref_clk_in,
  input  wire logic                                direct_sel_in,
  input  wire logic           [1:0]                skew_sel_in,
  input  wire logic                                pci_clk_in,
  input  wire logic                                pci_event_in,
  output clock_source_pkg::tree_type               core_tree_out,
  output clock_source_pkg::tree_type               pci_tree_out,
  output logic                                     pll_lock_out,
  output clock_source_pkg::clk_status_type         status_out,
  output logic                                     core_event_out,
  output logic                [`EVENT_CNT_W-1:0]   core_event_count_out
);
  import clock_source_pkg::*;

  pll_state_type             pll_state_ff;
  pll_state_type             nxt_pll_state;
  logic                      ref_q_ff;
  logic                      ref_rise;
  logic [`PERIOD_W-1:0]      period_cnt_ff;
  logic [`PERIOD_W-1:0]      last_period_ff;
  logic [`PERIOD_W-1:0]      step;
  logic [`PERIOD_W-1:0]      sub_cnt_ff;
  logic [1:0]                ticks_left_ff;
  logic [`LOCK_CNT_W-1:0]    stable_cnt_ff;
  logic                      period_ok;
  logic                      ref_lost;
  logic                      pll_tick;
  logic                      pll_lock_ff;
  logic                      core_base_ff;
  logic                      pci_q_ff;
  logic                      pci_base_ff;
  logic [`TAP_W-1:0]         gap_ab;
  logic [`TAP_W-1:0]         gap_bc;
  logic [`TAP_W-1:0]         tap [3];
  tree_type                  core_tree;
  tree_type                  pci_tree;
  logic                      pci_toggle;
  logic                      sync_one;
  logic                      sync_two;
  logic                      sync_three;
  logic [`EVENT_CNT_W-1:0]   event_cnt;
  logic                      core_event_ff;
  clk_status_type            status_ff;

  always_comb
  begin
    ref_rise = ref_clk_in & ~ref_q_ff;
  end

  always_ff @(posedge mclk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      ref_q_ff <= 1'b0;
    end
    else
    begin
      ref_q_ff <= ref_clk_in;
    end
  end

  // Reference period in system cycles, saturating so a stopped reference is seen.
  always_ff @(posedge mclk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      period_cnt_ff  <= '0;
      last_period_ff <= '0;
    end
    else if (pll_state_ff == PLL_OFF)
    begin
      period_cnt_ff  <= '0;
      last_period_ff <= '0;
    end
    else if (ref_rise)
    begin
      period_cnt_ff  <= `PERIOD_W'(1);
      last_period_ff <= period_cnt_ff;
    end
    else if (period_cnt_ff != `PERIOD_MAX)
    begin
      period_cnt_ff <= period_cnt_ff + `PERIOD_W'(1);
    end
  end

  always_comb
  begin
    period_ok = (period_cnt_ff >= `PERIOD_MIN) &&
                (period_cnt_ff <= last_period_ff + `PERIOD_TOL) &&
                (period_cnt_ff + `PERIOD_TOL >= last_period_ff);
    ref_lost  = (last_period_ff != '0) &&
                (period_cnt_ff > {last_period_ff[`PERIOD_W-2:0], 1'b0});
    step      = period_cnt_ff >> `PLL_MULT_LOG2;
  end

  // Loop state: powered down by the direct select, otherwise measure, acquire, lock.
  always_comb
  begin
    nxt_pll_state = pll_state_ff;
    case (pll_state_ff)
      PLL_OFF:
      begin
        nxt_pll_state = PLL_MEASURE;
      end
      PLL_MEASURE:
      begin
        if (ref_rise)
        begin
          nxt_pll_state = PLL_ACQUIRE;
        end
      end
      PLL_ACQUIRE:
      begin
        if (ref_lost)
        begin
          nxt_pll_state = PLL_MEASURE;
        end
        else if (ref_rise && period_ok && stable_cnt_ff == `LOCK_PERIODS - `LOCK_CNT_W'(1))
        begin
          nxt_pll_state = PLL_LOCKED;
        end
      end
      PLL_LOCKED:
      begin
        if (ref_lost || (ref_rise && !period_ok))
        begin
          nxt_pll_state = PLL_ACQUIRE;
        end
      end
      default:
      begin
        nxt_pll_state = PLL_OFF;
      end
    endcase
    if (direct_sel_in)
    begin
      nxt_pll_state = PLL_OFF;
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      pll_state_ff <= PLL_OFF;
    end
    else
    begin
      pll_state_ff <= nxt_pll_state;
    end
  end

  // Counts consecutive reference periods that agree within tolerance.
  always_ff @(posedge mclk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      stable_cnt_ff <= '0;
    end
    else if (pll_state_ff != PLL_ACQUIRE)
    begin
      stable_cnt_ff <= '0;
    end
    else if (ref_rise)
    begin
      stable_cnt_ff <= period_ok ? stable_cnt_ff + `LOCK_CNT_W'(1) : '0;
    end
  end

  always_comb
  begin
    pll_tick = 1'b0;
    if (pll_state_ff == PLL_ACQUIRE || pll_state_ff == PLL_LOCKED)
    begin
      if (ref_rise)
      begin
        pll_tick = 1'b1;
      end
      else if (ticks_left_ff != 2'h0 && sub_cnt_ff == '0)
      begin
        pll_tick = 1'b1;
      end
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      sub_cnt_ff    <= '0;
      ticks_left_ff <= 2'h0;
    end
    else if (pll_state_ff != PLL_ACQUIRE && pll_state_ff != PLL_LOCKED)
    begin
      sub_cnt_ff    <= '0;
      ticks_left_ff <= 2'h0;
    end
    else if (ref_rise)
    begin
      sub_cnt_ff    <= (step == '0) ? '0 : step - `PERIOD_W'(1);
      ticks_left_ff <= 2'(`PLL_MULT - 1);
    end
    else if (ticks_left_ff != 2'h0)
    begin
      if (sub_cnt_ff == '0)
      begin
        sub_cnt_ff    <= (last_period_ff >> `PLL_MULT_LOG2) - `PERIOD_W'(1);
        ticks_left_ff <= ticks_left_ff - 2'h1;
      end
      else
      begin
        sub_cnt_ff <= sub_cnt_ff - `PERIOD_W'(1);
      end
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      pll_lock_ff <= 1'b0;
    end
    else
    begin
      pll_lock_ff <= (nxt_pll_state == PLL_LOCKED);
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      core_base_ff <= 1'b0;
    end
    else
    begin
      core_base_ff <= direct_sel_in ? ref_rise : pll_tick;
    end
  end

  // bus trees from bus clock only
  always_ff @(posedge mclk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      pci_q_ff    <= 1'b0;
      pci_base_ff <= 1'b0;
    end
    else
    begin
      pci_q_ff    <= pci_clk_in;
      pci_base_ff <= pci_clk_in & ~pci_q_ff;
    end
  end

  // Reserved code 11 falls back to natural skew.
  always_comb
  begin
    gap_ab = '0;
    gap_bc = '0;
    case (skew_sel_in)
      `SKEW_MEDIUM:
      begin
        gap_ab = `TAP_W'(`D1_CYC);
        gap_bc = `TAP_W'(`D3_CYC);
      end
      `SKEW_MAXIMUM:
      begin
        gap_ab = `TAP_W'(`D1_CYC + `D2_CYC);
        gap_bc = `TAP_W'(`D3_CYC + `D4_CYC);
      end
      default:
      begin
        gap_ab = '0;
        gap_bc = '0;
      end
    endcase
    tap[0] = '0;
    tap[1] = gap_ab;
    tap[2] = gap_ab + gap_bc;
  end

  tree_delay_line #(.DEPTH(`TREE_DEPTH)) u_core_a
  (
    .mclk_in  (mclk_in),
    .rst_in   (rst_in),
    .tick_in  (core_base_ff),
    .tap_in   (tap[0]),
    .tick_out (core_tree.tree_copy_a)
  );

  tree_delay_line #(.DEPTH(`TREE_DEPTH)) u_core_b
  (
    .mclk_in  (mclk_in),
    .rst_in   (rst_in),
    .tick_in  (core_base_ff),
    .tap_in   (tap[1]),
    .tick_out (core_tree.tree_copy_b)
  );

  tree_delay_line #(.DEPTH(`TREE_DEPTH)) u_core_c
  (
    .mclk_in  (mclk_in),
    .rst_in   (rst_in),
    .tick_in  (core_base_ff),
    .tap_in   (tap[2]),
    .tick_out (core_tree.tree_copy_c)
  );

  tree_delay_line #(.DEPTH(`TREE_DEPTH)) u_pci_a
  (
    .mclk_in  (mclk_in),
    .rst_in   (rst_in),
    .tick_in  (pci_base_ff),
    .tap_in   (tap[0]),
    .tick_out (pci_tree.tree_copy_a)
  );

  tree_delay_line #(.DEPTH(`TREE_DEPTH)) u_pci_b
  (
    .mclk_in  (mclk_in),
    .rst_in   (rst_in),
    .tick_in  (pci_base_ff),
    .tap_in   (tap[1]),
    .tick_out (pci_tree.tree_copy_b)
  );

  tree_delay_line #(.DEPTH(`TREE_DEPTH)) u_pci_c
  (
    .mclk_in  (mclk_in),
    .rst_in   (rst_in),
    .tick_in  (pci_base_ff),
    .tap_in   (tap[2]),
    .tick_out (pci_tree.tree_copy_c)
  );

  always_comb
  begin
    core_tree_out = core_tree;
    pci_tree_out  = pci_tree;
  end

  tmr_register #(.WIDTH(1)) u_pci_toggle
  (
    .mclk_in (mclk_in),
    .rst_in  (rst_in),
    .tree_in (pci_tree),
    .d_in    (pci_toggle ^ pci_event_in),
    .q_out   (pci_toggle)
  );

  tmr_register #(.WIDTH(1)) u_sync_one
  (
    .mclk_in (mclk_in),
    .rst_in  (rst_in),
    .tree_in (core_tree),
    .d_in    (pci_toggle),
    .q_out   (sync_one)
  );

  tmr_register #(.WIDTH(1)) u_sync_two
  (
    .mclk_in (mclk_in),
    .rst_in  (rst_in),
    .tree_in (core_tree),
    .d_in    (sync_one),
    .q_out   (sync_two)
  );

  tmr_register #(.WIDTH(1)) u_sync_three
  (
    .mclk_in (mclk_in),
    .rst_in  (rst_in),
    .tree_in (core_tree),
    .d_in    (sync_two),
    .q_out   (sync_three)
  );

  tmr_register #(.WIDTH(`EVENT_CNT_W)) u_event_cnt
  (
    .mclk_in (mclk_in),
    .rst_in  (rst_in),
    .tree_in (core_tree),
    .d_in    (event_cnt + `EVENT_CNT_W'(sync_two ^ sync_three)),
    .q_out   (event_cnt)
  );

  // One pulse per crossed event, in the cycle after the first core tree tick.
  always_ff @(posedge mclk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      core_event_ff <= 1'b0;
    end
    else
    begin
      core_event_ff <= core_tree.tree_copy_a & (sync_two ^ sync_three);
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      status_ff <= '0;
    end
    else
    begin
      status_ff.pll_powered   <= (nxt_pll_state != PLL_OFF);
      status_ff.pll_locked    <= (nxt_pll_state == PLL_LOCKED);
      status_ff.direct_mode   <= direct_sel_in;
      status_ff.skew_reserved <= (skew_sel_in == `SKEW_RESERVED);
    end
  end

  always_comb
  begin
    pll_lock_out         = pll_lock_ff;
    status_out           = status_ff;
    core_event_out       = core_event_ff;
    core_event_count_out = event_cnt;
  end

endmodule

// [clock_gen_model.sv]
`timescale 1ns/1ps

// Board clock generator: reference and bus clocks as levels stepped on the system clock.
module clock_gen_model
(
  input  wire logic       mclk_in,
  input  wire logic       ref_en_in,
  input  wire logic [7:0] ref_half_in,
  input  wire logic       pci_en_in,
  input  wire logic [7:0] pci_half_in,
  output logic            ref_clk_out,
  output logic            pci_clk_out
);
  logic [7:0] ref_cnt;
  logic [7:0] pci_cnt;

  initial
  begin
    ref_clk_out = 1'b0;
    pci_clk_out = 1'b0;
    ref_cnt = 8'h00;
    pci_cnt = 8'h00;
  end

  // A stopped clock rests low so that no stray edge reaches the device.
  always @(posedge mclk_in)
  begin
    ref_cnt <= #1 (!ref_en_in || ref_cnt + 8'h01 >= ref_half_in) ? 8'h00 : ref_cnt + 8'h01;
    pci_cnt <= #1 (!pci_en_in || pci_cnt + 8'h01 >= pci_half_in) ? 8'h00 : pci_cnt + 8'h01;
    if (!ref_en_in)
      ref_clk_out <= #1 1'b0;
    else if (ref_cnt + 8'h01 >= ref_half_in)
      ref_clk_out <= #1 ~ref_clk_out;
    if (!pci_en_in)
      pci_clk_out <= #1 1'b0;
    else if (pci_cnt + 8'h01 >= pci_half_in)
      pci_clk_out <= #1 ~pci_clk_out;
  end
endmodule

// [clock_source_skew_chk.sv]
`timescale 1ns/1ps
`include "clock_source_defines.svh"

module clock_source_skew_chk
(
  input wire logic                              mclk_in,
  input wire logic                              rst_in,
  input wire logic                              ref_clk_in,
  input wire logic                              direct_sel_in,
  input wire logic [1:0]                        skew_sel_in,
  input wire logic                              pci_clk_in,
  input wire clock_source_pkg::tree_type        core_tree_out,
  input wire clock_source_pkg::tree_type        pci_tree_out,
  input wire logic                              pll_lock_out,
  input wire clock_source_pkg::clk_status_type  status_out,
  input wire logic [`EVENT_CNT_W-1:0]           core_event_count_out
);
  import clock_source_pkg::*;

  logic [1:0] skew_prev_ff;
  logic [3:0] skew_age_ff;

  // Ticks launched under an older code may still be in flight, so skew is judged once settled.
  always_ff @(posedge mclk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      skew_prev_ff <= 2'h0;
      skew_age_ff  <= 4'h0;
    end
    else
    begin
      skew_prev_ff <= skew_sel_in;
      if (skew_sel_in != skew_prev_ff)
        skew_age_ff <= 4'h0;
      else if (skew_age_ff != 4'hF)
        skew_age_ff <= skew_age_ff + 4'h1;
    end
  end

  default clocking @(posedge mclk_in);
  endclocking
  default disable iff (rst_in);

  direct_tick_a: assert property (
    direct_sel_in && $past(direct_sel_in) && $past(direct_sel_in, 2) && ref_clk_in
    && !$past(ref_clk_in) |-> ##2 core_tree_out.tree_copy_a)
    else $error("core tick missing after reference edge");
  bypass_unlock_a: assert property (direct_sel_in |=> !pll_lock_out)
    else $error("lock still high with direct select");
  power_off_a: assert property (
    direct_sel_in && $past(direct_sel_in) && $past(direct_sel_in, 2) |-> !status_out.pll_powered)
    else $error("loop powered in direct mode");
  lock_rise_a: assert property ($rose(pll_lock_out) |-> !$past(direct_sel_in))
    else $error("lock rose in direct mode");
  natural_skew_a: assert property (
    skew_age_ff >= 4'hC && skew_sel_in == skew_prev_ff && skew_sel_in inside {2'h0, 2'h3}
    && core_tree_out.tree_copy_a |-> core_tree_out.tree_copy_b && core_tree_out.tree_copy_c)
    else $error("natural skew trees not aligned");
  medium_skew_a: assert property (
    skew_age_ff >= 4'hC && skew_sel_in == skew_prev_ff && skew_sel_in == 2'h1
    && core_tree_out.tree_copy_c |-> $past(core_tree_out.tree_copy_b, 3)
    && $past(core_tree_out.tree_copy_a, 5))
    else $error("medium skew offsets wrong");
  max_skew_a: assert property (
    skew_age_ff >= 4'hC && skew_sel_in == skew_prev_ff && skew_sel_in == 2'h2
    && pci_tree_out.tree_copy_c |-> $past(pci_tree_out.tree_copy_b, 6)
    && $past(pci_tree_out.tree_copy_a, 10))
    else $error("maximum skew offsets wrong");
  pci_source_a: assert property (
    pci_tree_out.tree_copy_a |-> $past(pci_clk_in, 2) && !$past(pci_clk_in, 3))
    else $error("bus tick without bus clock edge");
  count_step_a: assert property (
    $changed(core_event_count_out) |-> core_event_count_out == $past(core_event_count_out) + 1'b1)
    else $error("crossed event count jumped");
endmodule

bind clock_source_skew clock_source_skew_chk clock_source_skew_chk_inst
(
  .mclk_in              (mclk_in),
  .rst_in               (rst_in),
  .ref_clk_in           (ref_clk_in),
  .direct_sel_in        (direct_sel_in),
  .skew_sel_in          (skew_sel_in),
  .pci_clk_in           (pci_clk_in),
  .core_tree_out        (core_tree_out),
  .pci_tree_out         (pci_tree_out),
  .pll_lock_out         (pll_lock_out),
  .status_out           (status_out),
  .core_event_count_out (core_event_count_out)
);

// [processor_clock_source_and_skew_bench.sv]
`timescale 1ns/1ps
`include "clock_source_defines.svh"

module processor_clock_source_and_skew_bench;
  import clock_source_pkg::*;

  logic                      mclk_in = 1'b0;
  logic                      rst_in = 1'b1;
  logic                      direct_sel_in = 1'b1;
  logic [1:0]                skew_sel_in = 2'h0;
  logic                      pci_event_in = 1'b0;
  logic                      ref_en = 1'b0;
  logic                      pci_en = 1'b0;
  logic [7:0]                ref_half = 8'h0A;
  logic                      ref_clk_in;
  logic                      pci_clk_in;
  tree_type                  core_tree_out;
  tree_type                  pci_tree_out;
  logic                      pll_lock_out;
  clk_status_type            status_out;
  logic                      core_event_out;
  logic [`EVENT_CNT_W-1:0]   core_event_count_out;
  int                        err_total = 0;
  int                        samples_checked = 0;
  int                        cyc = 0;
  int                        core_ticks = 0;
  int                        pci_ticks = 0;
  int                        pulses = 0;

  always #25 mclk_in = ~mclk_in;

  clock_gen_model clock_gen_model_inst (.mclk_in(mclk_in), .ref_en_in(ref_en),
    .ref_half_in(ref_half), .pci_en_in(pci_en), .pci_half_in(8'h0C),
    .ref_clk_out(ref_clk_in), .pci_clk_out(pci_clk_in));

  clock_source_skew clock_source_skew_inst (.mclk_in(mclk_in), .rst_in(rst_in),
    .ref_clk_in(ref_clk_in), .direct_sel_in(direct_sel_in), .skew_sel_in(skew_sel_in),
    .pci_clk_in(pci_clk_in), .pci_event_in(pci_event_in), .core_tree_out(core_tree_out),
    .pci_tree_out(pci_tree_out), .pll_lock_out(pll_lock_out), .status_out(status_out),
    .core_event_out(core_event_out), .core_event_count_out(core_event_count_out));

  task automatic conclude();
    $display("compared %0d, mismatched %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  always @(posedge mclk_in)
  begin
    cyc++;
    core_ticks += (core_tree_out.tree_copy_a === 1'b1);
    pci_ticks += (pci_tree_out.tree_copy_a === 1'b1);
    pulses += (core_event_out === 1'b1);
    if (cyc == 20000)
    begin
      err_total++;
      conclude();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      err_total++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic step(input int n);
    repeat (n) begin @(posedge mclk_in); #1; end
  endtask

  function automatic tree_type pick(input bit pci);
    return pci ? pci_tree_out : core_tree_out;
  endfunction

  // Cycles from tree a to b and from b to c for one tick.
  task automatic gaps(input bit pci, output int gab, output int gbc);
    int n;
    int tb;
    int tc;
    n = 0;
    tb = -1;
    tc = -1;
    while (pick(pci).tree_copy_a !== 1'b1 && n < 100) begin step(1); n++; end
    repeat (12)
    begin
      if (pick(pci).tree_copy_b === 1'b1 && tb < 0) tb = n;
      if (pick(pci).tree_copy_c === 1'b1 && tc < 0) tc = n;
      step(1);
      n++;
    end
    gab = tb - (n - 12);
    gbc = tc - tb;
  endtask

  task automatic wait_lock(input bit exp, input int limit);
    int n;
    n = 0;
    while (pll_lock_out !== exp && n < limit) begin step(1); n++; end
  endtask

  task automatic t_skew();
    int exp_ab[4] = '{0, 2, 4, 0};
    int exp_bc[4] = '{0, 3, 6, 0};
    int ab;
    int bc;
    // board drives only codes 00, 01 and 10
    for (int code = 0; code < 3; code++)
    begin
      skew_sel_in = code[1:0];
      step(14);
      gaps(1'b0, ab, bc);
      chk(ab, exp_ab[code]);
      chk(bc, exp_bc[code]);
      gaps(1'b1, ab, bc);
      chk(ab, exp_ab[code]);
      chk(bc, exp_bc[code]);
      chk(status_out.skew_reserved, code == 3);
    end
    skew_sel_in = 2'h0;
    step(14);
  endtask

  task automatic t_rate(input int cycles, input int exp);
    int c0;
    c0 = core_ticks;
    step(cycles);
    chk(core_ticks - c0, exp);
  endtask

  task automatic t_pci_quiet();
    int c0;
    int p0;
    pci_en = 1'b0;
    step(10);
    c0 = core_ticks;
    p0 = pci_ticks;
    step(40);
    chk(pci_ticks - p0, 0);
    chk(core_ticks - c0, 2);
    pci_en = 1'b1;
  endtask

  task automatic wait_c();
    int n;
    n = 0;
    while (pci_tree_out.tree_copy_c !== 1'b1 && n < 100) begin step(1); n++; end
  endtask

  task automatic t_events();
    int p0;
    logic [`EVENT_CNT_W-1:0] c0;
    p0 = pulses;
    c0 = core_event_count_out;
    repeat (3)
    begin
      wait_c();
      pci_event_in = 1'b1;
      step(1);
      wait_c();
      pci_event_in = 1'b0;
      step(2);
    end
    step(60);
    chk(core_event_count_out, c0 + 8'h03);
    chk(pulses - p0, 3);
  endtask

  initial
  begin
    step(12);
    rst_in = 1'b0;
    ref_en = 1'b1;
    pci_en = 1'b1;
    step(4);
    chk(status_out, 4'h2);
    t_skew();
    t_rate(80, 4);
    t_pci_quiet();
    ref_half = 8'h04;
    direct_sel_in = 1'b0;
    wait_lock(1'b1, 300);
    chk(pll_lock_out, 1'b1);
    chk(status_out.pll_locked, 1'b1);
    chk(status_out.pll_powered, 1'b1);
    t_rate(80, 40);
    t_events();
    ref_en = 1'b0;
    wait_lock(1'b0, 24);
    chk(pll_lock_out, 1'b0);
    ref_en = 1'b1;
    wait_lock(1'b1, 300);
    chk(pll_lock_out, 1'b1);
    direct_sel_in = 1'b1;
    step(1);
    chk(pll_lock_out, 1'b0);
    ref_half = 8'h0A;
    step(20);
    t_rate(80, 4);
    conclude();
  end
endmodule
